// ===== hdl/timer_pkg.sv
package timer_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT     = 8'h04;
  localparam logic [7:0] ADDR_COMPARE   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h10;

  // timer_control fields
  localparam int FOC_BIT    = 7;
  localparam int WGM_LO_BIT = 6;
  localparam int COM_HI_BIT = 5;
  localparam int COM_LO_BIT = 4;
  localparam int WGM_HI_BIT = 3;
  localparam int CS_MSB     = 2;

  // irq mask and flag positions
  localparam int OVF_BIT = 1;
  localparam int CMP_BIT = 0;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET    = 2'h0;
  localparam logic [1:0] FLAGS_RESET   = 2'h0;

  // waveform modes
  localparam logic [1:0] MODE_NORMAL   = 2'h0;
  localparam logic [1:0] MODE_PC_PWM   = 2'h1;
  localparam logic [1:0] MODE_CTC      = 2'h2;
  localparam logic [1:0] MODE_FAST_PWM = 2'h3;

  // compare output modes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // count sources
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_IO       = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // log2 of the prescaler taps: divide by 8, 64, 256, 1024
  localparam int NUM_TAPS = 4;
  localparam int PRESCALE_LOG2 [NUM_TAPS] = '{3, 6, 8, 10};

  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage

// ===== hdl/prescale_taps.sv
`timescale 1ns/100ps
module prescale_taps
  import timer_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_rst,
  output logic      [NUM_TAPS-1:0] o_tap
);
  localparam int CNT_W = PRESCALE_LOG2[NUM_TAPS-1];

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // one-cycle enable at the end of each tap period
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAPS; gi++) begin : g_tap
      assign o_tap[gi] = &cnt[PRESCALE_LOG2[gi]-1:0];
    end
  endgenerate
endmodule

// ===== hdl/ext_pin_sync.sv
`timescale 1ns/100ps
module ext_pin_sync (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);
  logic [2:0] stage;
  logic       level;
  wire        agree = stage[1] == stage[2];

  // stage[0] feeds stage[1] only
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stage  <= 3'h0;
      level  <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      stage  <= {stage[1:0], i_pin};
      if (agree) begin
        level <= stage[2];
      end
      o_rise <= agree && stage[2] && !level;
      o_fall <= agree && !stage[2] && level;
    end
  end
endmodule

// ===== hdl/timer8_pwm.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
module timer8_pwm (
  input  wire logic                          I_CLOCK,
  input  wire logic                          I_RST,
  input  wire logic                          I_PSEL,
  input  wire logic                          I_PENABLE,
  input  wire logic                          I_PWRITE,
  input  wire logic [timer_pkg::ADDR_W-1:0]  I_PADDR,
  input  wire logic [timer_pkg::DATA_W-1:0]  I_PWDATA,
  output logic      [timer_pkg::DATA_W-1:0]  O_PRDATA,
  output logic                               O_PREADY,
  output logic                               O_PSLVERR,
  input  wire logic                          I_EXT_COUNT,
  input  wire logic                          I_PIN_DIR_OUT,
  input  wire logic                          I_GLOBAL_IRQ_EN,
  input  wire logic                          I_OVF_ACK,
  input  wire logic                          I_CMP_ACK,
  output logic                               O_COMPARE_PIN,
  output logic                               O_COMPARE_PIN_OE,
  output logic                               O_COMPARE_OVERRIDE,
  output logic                               O_OVF_IRQ,
  output logic                               O_CMP_IRQ
);
  import timer_pkg::*;

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]          ctrl;
  logic [7:0]          count;
  logic [7:0]          cmp_buf;
  logic [7:0]          cmp_active;
  logic [1:0]          mask;
  logic                ovf;
  logic                ocf;
  logic                wave;
  logic                block;
  logic                force_pend;
  dir_t                dir;
  logic [7:0]          next_count;
  dir_t                next_dir;
  logic                next_wave;
  logic [NUM_TAPS-1:0] pre_tick;
  logic                ext_rise;
  logic                ext_fall;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        off);
    return a == off;
  endfunction

  wire setup     = I_PSEL && !I_PENABLE;
  wire wr        = I_PSEL && I_PENABLE && I_PWRITE;
  wire hit_ctrl  = is_reg(I_PADDR, ADDR_CONTROL);
  wire hit_count = is_reg(I_PADDR, ADDR_COUNT);
  wire hit_cmp   = is_reg(I_PADDR, ADDR_COMPARE);
  wire hit_mask  = is_reg(I_PADDR, ADDR_IRQ_MASK);
  wire hit_flags = is_reg(I_PADDR, ADDR_IRQ_FLAGS);
  wire mapped    = hit_ctrl || hit_count || hit_cmp || hit_mask || hit_flags;
  wire wr_ctrl   = wr && hit_ctrl;
  wire wr_count  = wr && hit_count;
  wire wr_cmp    = wr && hit_cmp;
  wire wr_mask   = wr && hit_mask;
  wire wr_flags  = wr && hit_flags;

  wire [7:0] rd_byte = hit_ctrl  ? ctrl :
                       hit_count ? count :
                       hit_cmp   ? cmp_buf :
                       hit_mask  ? {6'h00, mask} :
                       hit_flags ? {6'h00, ovf, ocf} : 8'h00;

  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA <= '0;
    end else if (setup && !I_PWRITE) begin
      O_PRDATA <= {24'h000000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  wire [1:0] mode = {ctrl[WGM_HI_BIT], ctrl[WGM_LO_BIT]};
  wire [1:0] com  = ctrl[COM_HI_BIT:COM_LO_BIT];
  wire [2:0] cs   = ctrl[CS_MSB:0];
  wire       pwm  = mode == MODE_PC_PWM || mode == MODE_FAST_PWM;
  wire [1:0] wr_mode = {I_PWDATA[WGM_HI_BIT], I_PWDATA[WGM_LO_BIT]};
  wire       wr_pwm  = wr_mode == MODE_PC_PWM || wr_mode == MODE_FAST_PWM;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ctrl       <= CONTROL_RESET;
      mask       <= MASK_RESET;
      force_pend <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= {1'b0, I_PWDATA[6:0]};
      end
      if (wr_mask) begin
        mask <= I_PWDATA[OVF_BIT:CMP_BIT];
      end
      force_pend <= wr_ctrl && I_PWDATA[FOC_BIT] && !wr_pwm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count source
  prescale_taps u_taps (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .o_tap   (pre_tick)
  );

  // pin is sampled whatever its direction
  ext_pin_sync u_ext (
    .i_clock (I_CLOCK),
    .i_rst   (I_RST),
    .i_pin   (I_EXT_COUNT),
    .o_rise  (ext_rise),
    .o_fall  (ext_fall)
  );

  wire [1:0] tap_sel = 2'(cs[1:0] + 2'h2);
  wire tap_on = cs >= CS_DIV8 && cs <= CS_DIV1024;
  wire tick   = cs == CS_IO ||
                (tap_on && pre_tick[tap_sel]) ||
                (cs == CS_EXT_FALL && ext_fall) ||
                (cs == CS_EXT_RISE && ext_rise);

  ////////////////////////////////////////////////////////////////////////////
  // compare and events
  wire [7:0] top      = mode == MODE_CTC ? cmp_active : COUNT_MAX;
  wire at_max_tick    = tick && count == COUNT_MAX;
  wire cmp_ev         = tick && count == cmp_active && !block;
  wire pwm_ignore     = pwm && com[1] && cmp_active == COUNT_MAX;
  wire wave_match     = cmp_ev && !pwm_ignore;
  wire ovf_ev         = mode == MODE_PC_PWM ?
                        tick && count == COUNT_BOTTOM && dir == DIR_DOWN :
                        at_max_tick;
  wire ovf_clr        = (wr_flags && I_PWDATA[OVF_BIT]) || I_OVF_ACK;
  wire ocf_clr        = (wr_flags && I_PWDATA[CMP_BIT]) || I_CMP_ACK;

  ////////////////////////////////////////////////////////////////////////////
  // counter sequencing
  always_comb begin
    next_count = count;
    next_dir   = dir;
    if (tick) begin
      case (mode)
        MODE_CTC: begin
          next_count = count == top && !block ?
                       COUNT_BOTTOM : count + 8'h01;
        end
        MODE_PC_PWM: begin
          if (dir == DIR_UP) begin
            if (count == COUNT_MAX) begin
              next_count = count - 8'h01;
              next_dir   = DIR_DOWN;
            end else begin
              next_count = count + 8'h01;
            end
          end else begin
            if (count == COUNT_BOTTOM) begin
              next_count = count + 8'h01;
              next_dir   = DIR_UP;
            end else begin
              next_count = count - 8'h01;
            end
          end
        end
        default: begin
          next_count = count + 8'h01;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      count <= COUNT_RESET;
      dir   <= DIR_UP;
      block <= 1'b0;
    end else begin
      count <= wr_count ? I_PWDATA[7:0] : next_count;
      dir   <= next_dir;
      if (wr_count) begin
        block <= 1'b1;
      end else if (tick) begin
        block <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare register, buffered in PWM modes
  wire [7:0] next_active = !pwm ? (wr_cmp ? I_PWDATA[7:0] : cmp_buf) :
                           at_max_tick ? cmp_buf : cmp_active;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cmp_buf    <= COMPARE_RESET;
      cmp_active <= COMPARE_RESET;
    end else begin
      if (wr_cmp) begin
        cmp_buf <= I_PWDATA[7:0];
      end
      cmp_active <= next_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generator
  always_comb begin
    next_wave = wave;
    case (mode)
      MODE_NORMAL, MODE_CTC: begin
        if (force_pend || wave_match) begin
          case (com)
            COM_TOGGLE: next_wave = ~wave;
            COM_CLEAR:  next_wave = 1'b0;
            COM_SET:    next_wave = 1'b1;
            default:    next_wave = wave;
          endcase
        end
      end
      MODE_FAST_PWM: begin
        if (at_max_tick && com[1]) begin
          next_wave = ~com[0];
        end else if (wave_match && com[1]) begin
          next_wave = com[0];
        end
      end
      MODE_PC_PWM: begin
        if (at_max_tick && pwm_ignore) begin
          next_wave = ~com[0];
        end else if (wave_match && com[1]) begin
          next_wave = dir == DIR_UP ? com[0] : ~com[0];
        end
      end
      default: next_wave = wave;
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end

  assign O_COMPARE_PIN      = wave;
  assign O_COMPARE_OVERRIDE = com != COM_OFF;
  assign O_COMPARE_PIN_OE   = O_COMPARE_OVERRIDE && I_PIN_DIR_OUT;

  ////////////////////////////////////////////////////////////////////////////
  // flags, set beats clear
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      {ovf, ocf} <= FLAGS_RESET;
    end else begin
      ovf <= ovf_ev || (ovf && !ovf_clr);
      ocf <= cmp_ev || (ocf && !ocf_clr);
    end
  end

  assign O_OVF_IRQ = mask[OVF_BIT] && I_GLOBAL_IRQ_EN && ovf;
  assign O_CMP_IRQ = mask[CMP_BIT] && I_GLOBAL_IRQ_EN && ocf;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pc_peak;
    tick && mode == MODE_PC_PWM && count == COUNT_MAX && dir == DIR_UP &&
    !wr_count;
  endsequence
  sequence s_pc_fall;
    count == COUNT_MAX - 8'h01 && dir == DIR_DOWN;
  endsequence

  property p_force_wave;
    force_pend && !pwm && com == COM_TOGGLE && !wave_match
      |=> wave != $past(wave);
  endproperty
  a_force_wave: assert property (p_force_wave)
    else $error("force did not toggle output");

  property p_force_quiet;
    force_pend && !cmp_ev && !ocf_clr |=> $stable(ocf);
  endproperty
  a_force_quiet: assert property (p_force_quiet)
    else $error("force changed compare flag");

  property p_foc_read;
    setup && !I_PWRITE && hit_ctrl |=> !O_PRDATA[FOC_BIT];
  endproperty
  a_foc_read: assert property (p_foc_read)
    else $error("force strobe read as one");

  property p_ovf_max;
    at_max_tick && mode != MODE_PC_PWM |=> ovf;
  endproperty
  a_ovf_max: assert property (p_ovf_max)
    else $error("overflow flag missing at MAX");

  property p_buffered;
    wr_cmp && pwm && !at_max_tick |=> $stable(cmp_active);
  endproperty
  a_buffered: assert property (p_buffered)
    else $error("PWM compare updated before TOP");

  property p_pin_off;
    com == COM_OFF |-> !O_COMPARE_PIN_OE;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin driven while disconnected");

  property p_clear;
    wave_match && !pwm && com == COM_CLEAR |=> !O_COMPARE_PIN;
  endproperty
  a_clear: assert property (p_clear)
    else $error("output not cleared on match");

  property p_fast_top;
    at_max_tick && mode == MODE_FAST_PWM && com == COM_CLEAR
      |=> O_COMPARE_PIN;
  endproperty
  a_fast_top: assert property (p_fast_top)
    else $error("fast PWM output not set at TOP");

  property p_pc_up;
    wave_match && mode == MODE_PC_PWM && dir == DIR_UP && com == COM_CLEAR
      |=> !O_COMPARE_PIN;
  endproperty
  a_pc_up: assert property (p_pc_up)
    else $error("phase-correct up match did not clear");

  property p_stop;
    cs == CS_STOP && !wr_count && !wr_ctrl |=> $stable(count);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");

  property p_block;
    wr_count |=> !cmp_ev;
  endproperty
  a_block: assert property (p_block)
    else $error("match not blocked after count write");

  property p_ocf;
    cmp_ev |=> ocf;
  endproperty
  a_ocf: assert property (p_ocf)
    else $error("compare flag not set on match");

  property p_irq;
    $rose(ocf) && mask[CMP_BIT] && I_GLOBAL_IRQ_EN |-> O_CMP_IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("compare interrupt not raised");

  property p_ack;
    I_OVF_ACK && !ovf_ev |=> !ovf;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge did not clear overflow");

  property p_w1c;
    wr_flags && I_PWDATA[CMP_BIT] && !cmp_ev |=> !ocf;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");

  property p_ctc_clear;
    tick && mode == MODE_CTC && cmp_ev && !wr_count |=> count == 8'h00;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("counter not cleared on compare");

  property p_pc_turn;
    s_pc_peak |=> s_pc_fall;
  endproperty
  a_pc_turn: assert property (p_pc_turn)
    else $error("phase-correct turn at MAX wrong");
endmodule

// ===== verif/tb_timer8_pwm.sv
`timescale 1ns/100ps
module tb_timer8_pwm;
  import timer_pkg::*;

  logic              clk;
  logic              rst;
  logic              psel;
  logic              pen;
  logic              pwr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              ext;
  logic              dir;
  logic              gie;
  logic              oack;
  logic              cack;
  logic              pin;
  logic              oe;
  logic              ovr;
  logic              oirq;
  logic              cirq;
  int                failures;
  int                check_count;
  logic [31:0]       rd;
  logic              err;
  int                hi;
  int                expect_hi;
  logic [2:0]        cs_tab [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  int                div_tab [5] = '{1, 8, 64, 256, 1024};
  logic [1:0]        com_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
  logic              pin_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  timer8_pwm u_timer8_pwm (
    .I_CLOCK            (clk),
    .I_RST              (rst),
    .I_PSEL             (psel),
    .I_PENABLE          (pen),
    .I_PWRITE           (pwr),
    .I_PADDR            (paddr),
    .I_PWDATA           (pwdata),
    .O_PRDATA           (prdata),
    .O_PREADY           (pready),
    .O_PSLVERR          (pslverr),
    .I_EXT_COUNT        (ext),
    .I_PIN_DIR_OUT      (dir),
    .I_GLOBAL_IRQ_EN    (gie),
    .I_OVF_ACK          (oack),
    .I_CMP_ACK          (cack),
    .O_COMPARE_PIN      (pin),
    .O_COMPARE_PIN_OE   (oe),
    .O_COMPARE_OVERRIDE (ovr),
    .O_OVF_IRQ          (oirq),
    .O_CMP_IRQ          (cirq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    stop_test();
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    if (n >= 50) failures++;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, rd, exp);
  endtask

  function automatic logic [7:0] ctl(input logic [1:0] m,
                                     input logic [1:0] com,
                                     input logic [2:0] cs);
    return {1'b0, m[0], com, m[1], cs};
  endfunction

  task automatic pulses(input int k);
    repeat (k) begin
      repeat (4) @(posedge clk);
      ext <= 1'b1;
      repeat (4) @(posedge clk);
      ext <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext = 1'b0;
    dir = 1'b1;
    gie = 1'b1;
    oack = 1'b0;
    cack = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;

    // reset values and unmapped access
    rdchk("control", ADDR_CONTROL, 32'h0);
    rdchk("mask", ADDR_IRQ_MASK, 32'h0);
    rdchk("flags", ADDR_IRQ_FLAGS, 32'h0);
    apb(1'b0, 8'h14, 8'h00);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    chk("ready", {31'h0, pready}, 32'h1);
    $display("test reset done");

    // forced compare, stopped in normal mode
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CONTROL, 8'h80 | ctl(MODE_NORMAL, com_tab[i], CS_STOP));
      repeat (3) @(posedge clk);
      chk("force_pin", {31'h0, pin}, {31'h0, pin_tab[i]});
      chk("override", {31'h0, ovr}, 32'h1);
      rdchk("force_reads_zero", ADDR_CONTROL,
            {26'h0, com_tab[i], 4'h0});
    end
    chk("oe_out", {31'h0, oe}, 32'h1);
    dir <= 1'b0;
    @(negedge clk);
    chk("oe_in", {31'h0, oe}, 32'h0);
    @(posedge clk);
    dir <= 1'b1;
    rdchk("force_no_flag", ADDR_IRQ_FLAGS, 32'h0);
    apb(1'b1, ADDR_COUNT, 8'h5A);
    rdchk("count_rw", ADDR_COUNT, 32'h5A);
    $display("test force done");

    // clear-on-compare with compare interrupt
    apb(1'b1, ADDR_COMPARE, 8'h02);
    apb(1'b1, ADDR_COUNT, 8'h01);
    apb(1'b1, ADDR_CONTROL, 8'h80 | ctl(MODE_CTC, COM_SET, CS_STOP));
    rdchk("force_no_clear", ADDR_COUNT, 32'h1);
    chk("ctc_force_pin", {31'h0, pin}, 32'h1);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_CTC, COM_CLEAR, CS_IO));
    repeat (50) @(posedge clk);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_CTC, COM_CLEAR, CS_STOP));
    chk("ctc_pin", {31'h0, pin}, 32'h0);
    apb(1'b0, ADDR_COUNT, 8'h00);
    chk("ctc_wrap", {31'h0, rd <= 32'h2}, 32'h1);
    rdchk("ctc_flags", ADDR_IRQ_FLAGS, 32'h1);
    apb(1'b1, ADDR_IRQ_MASK, 8'h01);
    @(negedge clk);
    chk("cmp_irq", {31'h0, cirq}, 32'h1);
    @(posedge clk);
    gie <= 1'b0;
    @(negedge clk);
    chk("cmp_irq_gie", {31'h0, cirq}, 32'h0);
    @(posedge clk);
    gie <= 1'b1;
    apb(1'b1, ADDR_IRQ_FLAGS, 8'h00);
    rdchk("w0_keeps", ADDR_IRQ_FLAGS, 32'h1);
    @(posedge clk);
    cack <= 1'b1;
    @(posedge clk);
    cack <= 1'b0;
    @(negedge clk);
    chk("ack_irq", {31'h0, cirq}, 32'h0);
    rdchk("ack_clears", ADDR_IRQ_FLAGS, 32'h0);
    $display("test ctc done");

    // overflow in normal mode
    apb(1'b1, ADDR_COMPARE, 8'h02);
    apb(1'b1, ADDR_COUNT, 8'hFA);
    apb(1'b1, ADDR_IRQ_MASK, 8'h02);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_IO));
    repeat (20) @(posedge clk);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
    rdchk("ovf_flag", ADDR_IRQ_FLAGS, 32'h3);
    chk("ovf_irq", {31'h0, oirq}, 32'h1);
    apb(1'b1, ADDR_IRQ_FLAGS, 8'h01);
    rdchk("w1_clears", ADDR_IRQ_FLAGS, 32'h2);
    chk("ovf_irq_on", {31'h0, oirq}, 32'h1);
    @(posedge clk);
    oack <= 1'b1;
    @(posedge clk);
    oack <= 1'b0;
    @(negedge clk);
    chk("ovf_irq_off", {31'h0, oirq}, 32'h0);
    rdchk("ovf_ack_clears", ADDR_IRQ_FLAGS, 32'h0);
    $display("test overflow done");

    // external count on both edges, pin set as output
    apb(1'b1, ADDR_COUNT, 8'h00);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_EXT_RISE));
    pulses(3);
    rdchk("ext_rise", ADDR_COUNT, 32'h3);
    apb(1'b1, ADDR_COUNT, 8'h00);
    apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_EXT_FALL));
    pulses(2);
    rdchk("ext_fall", ADDR_COUNT, 32'h2);
    $display("test external done");

    // internal sources: eight periods of each
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
      apb(1'b1, ADDR_COUNT, 8'h00);
      apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, cs_tab[i]));
      repeat (8 * div_tab[i]) @(posedge clk);
      apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
      apb(1'b0, ADDR_COUNT, 8'h00);
      chk("prescale", {31'h0, rd >= 32'h7 && rd <= 32'hB}, 32'h1);
    end
    $display("test prescaler done");

    // pwm duty and polarity, compare 0x40
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CONTROL, ctl(MODE_NORMAL, COM_OFF, CS_STOP));
      apb(1'b1, ADDR_COMPARE, 8'h40);
      apb(1'b1, ADDR_COUNT, 8'h00);
      apb(1'b1, ADDR_CONTROL, ctl(i < 2 ? MODE_FAST_PWM : MODE_PC_PWM,
                                  i[0] ? COM_SET : COM_CLEAR, CS_IO));
      repeat (600) @(posedge clk);
      hi = 0;
      repeat (1020) begin
        @(negedge clk);
        if (pin === 1'b1) hi++;
      end
      expect_hi = i[0] ? 762 : 258;
      chk("pwm_duty", {31'h0, hi > expect_hi - 16 && hi < expect_hi + 16},
          32'h1);
    end
    $display("test pwm done");
    stop_test();
  end
endmodule
